/* File: hw/ptp_event_cfg.svh */
`ifndef PTP_EVENT_CFG_SVH
`define PTP_EVENT_CFG_SVH

// Register byte offsets, compared against haddr[15:0]
`define OFS_UNIT_INDEX   16'h0520
`define OFS_MONITOR0     16'h0524
`define OFS_IRQ_STATUS   16'h0528
`define OFS_UNIT_CTRL    16'h052c
`define OFS_PULSE_CFG    16'h05c0
`define OFS_CAPTURE_STAT 16'h05c4

// Unit counts
`define NUM_PULSE 3
`define NUM_CAP   2
`define NUM_PIN   2

// Index register fields
`define IDX_PULSE_LSB 0
`define IDX_CAP_BIT   8
`define IDX_PIN_BIT   16
`define PULSE_SEL_RSVD 2'h3

// Interrupt status and monitor fields
`define STAT_PULSE_LSB 16
`define STAT_CAP_LSB   0
`define MON_ERR_LSB    16
`define MON_DONE_LSB   0

// Unit control fields
`define CTRL_OUT_SEL   8
`define CTRL_PIN_IN    7
`define CTRL_DIR       6
`define CTRL_CAP_IRQ   5
`define CTRL_PU_ACTIVE 4
`define CTRL_PU_EN     3
`define CTRL_PU_SRST   2
`define CTRL_CAP_EN    1
`define CTRL_CAP_SRST  0

// Pulse unit config and capture status fields
`define PCFG_NOTIFY    0
`define PCFG_DELAY_LSB 8
`define DELAY_W        16
`define DELAY_ONE      16'h0001
`define DELAY_ZERO     16'h0000
`define CSTAT_CNT_LSB  0
`define CAP_CNT_W      4
`define CAP_CNT_MAX    4'hf
`define CAP_CNT_ONE    4'h1
`define CSTAT_READY    8
`define CSTAT_OVFL     9

// AHB encodings
`define HSIZE_WORD 3'h2

`endif

/* File: hw/ptp_event_pkg.sv */
package ptp_event_pkg;

  // Pulse unit sequencing
  typedef enum logic [1:0] {
    PU_IDLE  = 2'b00,
    PU_COUNT = 2'b01
  } pulse_state_e;

  // One pulse output unit
  typedef struct packed {
    pulse_state_e state;
    logic         en;
    logic         err;
    logic         notify;
    logic         srst;
    logic [15:0]  delay;
    logic [15:0]  cnt;
  } pulse_unit_s;

  // One capture input unit
  typedef struct packed {
    logic       en;
    logic       irq_en;
    logic       srst;
    logic       ready;
    logic       ovfl;
    logic [3:0] cnt;
  } capture_unit_s;

  // Captured AHB address phase
  typedef struct packed {
    logic [15:0] addr;
    logic        write;
    logic        word;
  } ahb_req_s;

endpackage

/* File: hw/pin_sync.sv */
`timescale 1ns/1ns
`include "ptp_event_cfg.svh"

// Two-stage synchroniser for the event pins
module pin_sync (
  input  wire logic                 clk_sys,
  input  wire logic                 rst_b,
  input  wire logic [`NUM_PIN-1:0] d,
  output logic      [`NUM_PIN-1:0] q
);

  logic [`NUM_PIN-1:0] meta_q;  // First stage, read only by the second

  // Pins are asynchronous to clk_sys
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule

/* File: hw/ptp_gpio_event_unit_control.sv */
// Register access over AHB-Lite was left to the implementer.
`timescale 1ns/1ns
`include "ptp_event_cfg.svh"
module ptp_gpio_event_unit_control (
  input  wire logic                 clk_sys,
  input  wire logic                 rst_b,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic                      hresp,
  output logic      [31:0]          hrdata,
  input  wire logic [`NUM_PIN-1:0] pin_in,
  output logic      [`NUM_PIN-1:0] pin_out,
  output logic      [`NUM_PIN-1:0] pin_oe,
  output logic                      pin_event_any
);

  // Bus slave state
  ptp_event_pkg::ahb_req_s acc_q;       // Captured address phase
  logic                    pend_q;      // Wait state of the data phase in progress
  logic                    hreadyout_q; // Ready towards the master
  logic [31:0]             hrdata_q;    // Read data
  logic                    hresp_q;     // Always OKAY

  // Index pointers
  logic [1:0] pulse_sel_q; // Pulse unit selector
  logic       cap_sel_q;   // Capture unit selector
  logic       pin_sel_q;   // Pin selector

  // Units and pins
  ptp_event_pkg::pulse_unit_s   pu_q  [`NUM_PULSE];
  ptp_event_pkg::pulse_unit_s   pu_d  [`NUM_PULSE];
  ptp_event_pkg::capture_unit_s cap_q [`NUM_CAP];
  ptp_event_pkg::capture_unit_s cap_d [`NUM_CAP];
  logic [`NUM_PULSE-1:0] pu_fire;   // Unit reached its target
  logic [`NUM_PULSE-1:0] pu_late;   // Unit started with no time left
  logic [`NUM_CAP-1:0]   cap_event; // Qualified capture edge
  logic [`NUM_PIN-1:0]   dir_q;     // 1 = capture input
  logic [`NUM_PIN-1:0]   out_sel_q; // 1 = direct drive
  logic [`NUM_PIN-1:0]   level_q;   // Trigger result per pin
  logic [`NUM_PIN-1:0]   level_d;
  logic [`NUM_PIN-1:0]   pin_s;     // Synchronised pin levels
  logic [`NUM_PIN-1:0]   pin_prev_q;
  logic [`NUM_PIN-1:0]   pin_out_q;
  logic [`NUM_PIN-1:0]   pin_oe_q;

  // Interrupt status
  logic [`NUM_PULSE-1:0] pulse_irq_q;
  logic [`NUM_PULSE-1:0] pulse_irq_d;
  logic [`NUM_CAP-1:0]   cap_irq_q;
  logic [`NUM_CAP-1:0]   cap_irq_d;
  logic                  irq_any_q;

  // Decoded write strobes and read data
  logic        wr_en;
  logic        wr_index;
  logic        wr_status;
  logic        wr_ctrl;
  logic        wr_pcfg;
  logic [31:0] rd_v;

  // Address match, shared by write and read decode
  function automatic logic reg_hit(input logic [15:0] addr, input logic [15:0] ofs);
    reg_hit = (addr == ofs);
  endfunction

  // Sticky flag update where a new event beats a clear
  function automatic logic sticky(input logic q, input logic clr, input logic set);
    sticky = (q & ~clr) | set;
  endfunction

  pin_sync u_pin_sync (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .d       (pin_in),
    .q       (pin_s)
  );

  assign hreadyout     = hreadyout_q;
  assign hresp         = hresp_q;
  assign hrdata        = hrdata_q;
  assign pin_out       = pin_out_q;
  assign pin_oe        = pin_oe_q;
  assign pin_event_any = irq_any_q;

  // Writes land at the end of the wait state, the first data-phase cycle, full words only
  assign wr_en     = pend_q & acc_q.write & acc_q.word;
  assign wr_index  = wr_en & reg_hit(acc_q.addr, `OFS_UNIT_INDEX);
  assign wr_status = wr_en & reg_hit(acc_q.addr, `OFS_IRQ_STATUS);
  assign wr_ctrl   = wr_en & reg_hit(acc_q.addr, `OFS_UNIT_CTRL);
  assign wr_pcfg   = wr_en & reg_hit(acc_q.addr, `OFS_PULSE_CFG);

  // Every transfer takes one wait state so reads see settled writes
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      acc_q       <= '0;
      pend_q      <= 1'b0;
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
    end else if (pend_q) begin
      pend_q      <= 1'b0;
      hreadyout_q <= 1'b1;
    end else if (hsel && htrans[1] && hready) begin
      acc_q.addr  <= haddr[15:0];
      acc_q.write <= hwrite;
      acc_q.word  <= (hsize == `HSIZE_WORD);
      pend_q      <= 1'b1;
      hreadyout_q <= 1'b0;
    end
  end

  // Read data is sampled while the wait state is up
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      hrdata_q <= '0;
    end else if (pend_q && !acc_q.write) begin
      hrdata_q <= rd_v;
    end
  end

  // Index pointers
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pulse_sel_q <= 2'h0;
      cap_sel_q   <= 1'b0;
      pin_sel_q   <= 1'b0;
    end else if (wr_index) begin
      pulse_sel_q <= hwdata[`IDX_PULSE_LSB +: 2];
      cap_sel_q   <= hwdata[`IDX_CAP_BIT];
      pin_sel_q   <= hwdata[`IDX_PIN_BIT];
    end
  end

  // Pulse unit sequencing and control writes
  always_comb begin
    pu_fire = '0;
    pu_late = '0;
    for (int u = 0; u < `NUM_PULSE; u++) begin
      pu_d[u] = pu_q[u];
      // Count down towards the target
      if (pu_q[u].state == ptp_event_pkg::PU_COUNT) begin
        if (pu_q[u].cnt == `DELAY_ONE) begin
          pu_fire[u]    = 1'b1;
          pu_d[u].state = ptp_event_pkg::PU_IDLE;
          pu_d[u].en    = 1'b0;
        end else begin
          pu_d[u].cnt = pu_q[u].cnt - `DELAY_ONE;
        end
      end
      // Selector value 3 matches no unit
      if (wr_ctrl && pulse_sel_q == u[1:0]) begin
        pu_d[u].srst = hwdata[`CTRL_PU_SRST];
        if (hwdata[`CTRL_PU_EN]) begin
          // Re-writing 1 to a running unit leaves it alone
          if (!pu_q[u].en) begin
            pu_d[u].en = 1'b1;
            if (pu_q[u].delay == `DELAY_ZERO) begin
              pu_d[u].err = 1'b1;
              pu_late[u]  = 1'b1;
            end else begin
              pu_d[u].state = ptp_event_pkg::PU_COUNT;
              pu_d[u].cnt   = pu_q[u].delay;
            end
          end
        end else begin
          pu_d[u].en    = 1'b0;
          pu_d[u].err   = 1'b0;
          pu_d[u].state = ptp_event_pkg::PU_IDLE;
        end
      end
      if (wr_pcfg && pulse_sel_q == u[1:0]) begin
        pu_d[u].notify = hwdata[`PCFG_NOTIFY];
        pu_d[u].delay  = hwdata[`PCFG_DELAY_LSB +: `DELAY_W];
      end
      // Held in defaults while soft reset is written as 1
      if (pu_d[u].srst) begin
        pu_d[u]      = '0;
        pu_d[u].srst = 1'b1;
        pu_fire[u]   = 1'b0;
        pu_late[u]   = 1'b0;
      end
    end
  end

  // Pulse unit registers
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      for (int u = 0; u < `NUM_PULSE; u++) begin
        pu_q[u] <= '0;
      end
    end else begin
      for (int u = 0; u < `NUM_PULSE; u++) begin
        pu_q[u] <= pu_d[u];
      end
    end
  end

  // Capture units; an edge in the same cycle as a clear still counts
  always_comb begin
    for (int c = 0; c < `NUM_CAP; c++) begin
      cap_d[c]     = cap_q[c];
      cap_event[c] = pin_s[c] & ~pin_prev_q[c] & cap_q[c].en & dir_q[c];
      if (wr_ctrl && cap_sel_q == c[0]) begin
        cap_d[c].irq_en = hwdata[`CTRL_CAP_IRQ];
        cap_d[c].srst   = hwdata[`CTRL_CAP_SRST];
        if (hwdata[`CTRL_CAP_EN]) begin
          cap_d[c].en  = 1'b1;
          cap_d[c].cnt = '0;
        end else begin
          cap_d[c].en    = 1'b0;
          cap_d[c].ready = 1'b0;
          cap_d[c].ovfl  = 1'b0;
        end
      end
      if (cap_event[c]) begin
        cap_d[c].ready = 1'b1;
        if (cap_d[c].cnt == `CAP_CNT_MAX) begin
          cap_d[c].ovfl = 1'b1;
        end else begin
          cap_d[c].cnt = cap_d[c].cnt + `CAP_CNT_ONE;
        end
      end
      if (cap_d[c].srst) begin
        cap_d[c]      = '0;
        cap_d[c].srst = 1'b1;
        cap_event[c]  = 1'b0;
      end
    end
  end

  // Capture unit registers and edge history
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      for (int c = 0; c < `NUM_CAP; c++) begin
        cap_q[c] <= '0;
      end
      pin_prev_q <= '0;
    end else begin
      for (int c = 0; c < `NUM_CAP; c++) begin
        cap_q[c] <= cap_d[c];
      end
      pin_prev_q <= pin_s;
    end
  end

  // Per-pin configuration follows the pin selector
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      dir_q     <= '0;
      out_sel_q <= '0;
    end else if (wr_ctrl) begin
      dir_q[pin_sel_q]     <= hwdata[`CTRL_DIR];
      out_sel_q[pin_sel_q] <= hwdata[`CTRL_OUT_SEL];
    end
  end

  // Trigger result: even units toggle pin 0, odd units pin 1
  always_comb begin
    level_d = level_q;
    for (int u = 0; u < `NUM_PULSE; u++) begin
      if (pu_fire[u]) begin
        level_d[u % `NUM_PIN] = ~level_d[u % `NUM_PIN];
      end
    end
  end

  // Direct drive shows the result at the firing edge, flopped one later
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      level_q   <= '0;
      pin_out_q <= '0;
      pin_oe_q  <= '0;
    end else begin
      level_q <= level_d;
      for (int p = 0; p < `NUM_PIN; p++) begin
        pin_out_q[p] <= out_sel_q[p] ? level_d[p] : level_q[p];
      end
      pin_oe_q <= ~dir_q;
    end
  end

  // Sticky status; set beats a write-one clear
  always_comb begin
    for (int u = 0; u < `NUM_PULSE; u++) begin
      pulse_irq_d[u] = sticky(pulse_irq_q[u],
                              wr_status & hwdata[`STAT_PULSE_LSB + u],
                              (pu_fire[u] | pu_late[u]) & pu_q[u].notify);
    end
    for (int c = 0; c < `NUM_CAP; c++) begin
      cap_irq_d[c] = sticky(cap_irq_q[c],
                            wr_status & hwdata[`STAT_CAP_LSB + c],
                            cap_event[c] & cap_q[c].irq_en);
    end
  end

  // Status registers and the global event bit
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pulse_irq_q <= '0;
      cap_irq_q   <= '0;
      irq_any_q   <= 1'b0;
    end else begin
      pulse_irq_q <= pulse_irq_d;
      cap_irq_q   <= cap_irq_d;
      irq_any_q   <= |{pulse_irq_d, cap_irq_d};
    end
  end

  // Read decode; unmapped offsets and reserved bits read zero
  always_comb begin
    ptp_event_pkg::pulse_unit_s   pu_r;
    ptp_event_pkg::capture_unit_s cap_r;
    pu_r  = '0;
    cap_r = cap_q[cap_sel_q];
    rd_v  = '0;
    if (pulse_sel_q != `PULSE_SEL_RSVD) begin
      pu_r = pu_q[pulse_sel_q];
    end
    if (reg_hit(acc_q.addr, `OFS_UNIT_INDEX)) begin
      rd_v[`IDX_PULSE_LSB +: 2] = pulse_sel_q;
      rd_v[`IDX_CAP_BIT]        = cap_sel_q;
      rd_v[`IDX_PIN_BIT]        = pin_sel_q;
    end else if (reg_hit(acc_q.addr, `OFS_MONITOR0)) begin
      for (int u = 0; u < `NUM_PULSE; u++) begin
        rd_v[`MON_ERR_LSB + u]  = pu_q[u].err;
        rd_v[`MON_DONE_LSB + u] = pulse_irq_q[u];
      end
    end else if (reg_hit(acc_q.addr, `OFS_IRQ_STATUS)) begin
      rd_v[`STAT_PULSE_LSB +: `NUM_PULSE] = pulse_irq_q;
      rd_v[`STAT_CAP_LSB +: `NUM_CAP]     = cap_irq_q;
    end else if (reg_hit(acc_q.addr, `OFS_UNIT_CTRL)) begin
      rd_v[`CTRL_OUT_SEL]   = out_sel_q[pin_sel_q];
      rd_v[`CTRL_PIN_IN]    = pin_s[pin_sel_q];
      rd_v[`CTRL_DIR]       = dir_q[pin_sel_q];
      rd_v[`CTRL_CAP_IRQ]   = cap_r.irq_en;
      rd_v[`CTRL_PU_ACTIVE] = (pu_r.state == ptp_event_pkg::PU_COUNT) & ~pu_r.err;
      rd_v[`CTRL_PU_EN]     = pu_r.en;
      rd_v[`CTRL_PU_SRST]   = pu_r.srst;
      rd_v[`CTRL_CAP_EN]    = cap_r.en;
      rd_v[`CTRL_CAP_SRST]  = cap_r.srst;
    end else if (reg_hit(acc_q.addr, `OFS_PULSE_CFG)) begin
      rd_v[`PCFG_NOTIFY]                = pu_r.notify;
      rd_v[`PCFG_DELAY_LSB +: `DELAY_W] = pu_r.delay;
    end else if (reg_hit(acc_q.addr, `OFS_CAPTURE_STAT)) begin
      rd_v[`CSTAT_CNT_LSB +: `CAP_CNT_W] = cap_r.cnt;
      rd_v[`CSTAT_READY]                 = cap_r.ready;
      rd_v[`CSTAT_OVFL]                  = cap_r.ovfl;
    end
  end

endmodule

/* File: dv/ptp_event_props.sv */
`timescale 1ns/1ns
`include "ptp_event_cfg.svh"
// Port checks of the bus answer, the status summary and the pin direction
module ptp_event_props (
  input wire logic                clk_sys,
  input wire logic                rst_b,
  input wire logic                hsel,
  input wire logic [31:0]         haddr,
  input wire logic [1:0]          htrans,
  input wire logic                hwrite,
  input wire logic [2:0]          hsize,
  input wire logic [31:0]         hwdata,
  input wire logic                hready,
  input wire logic                hreadyout,
  input wire logic                hresp,
  input wire logic [31:0]         hrdata,
  input wire logic [`NUM_PIN-1:0] pin_in,
  input wire logic [`NUM_PIN-1:0] pin_out,
  input wire logic [`NUM_PIN-1:0] pin_oe,
  input wire logic                pin_event_any
);
  logic        ph_q;   // Address phase taken
  logic [15:0] pa_q;   // Its offset
  logic        pw_q;   // Its direction
  logic        dn_q;   // Wait state ended at the last edge; data phase ends at the next
  logic [15:0] da_q;   // Offset of that transfer
  logic        dw_q;   // Direction of that transfer
  logic [31:0] wd_q;   // Write data of that transfer
  logic [1:0]  up_q;   // Edges since reset, so power-up moves are ignored
  logic        rd;
  logic        wr;
  logic        wrc;
  assign rd  = dn_q && !dw_q;
  assign wr  = dn_q && dw_q;
  assign wrc = wr && da_q == 16'h052c;

  // Follow each transfer from address phase to its end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ph_q <= 1'b0;
      pa_q <= 16'h0000;
      pw_q <= 1'b0;
      dn_q <= 1'b0;
      da_q <= 16'h0000;
      dw_q <= 1'b0;
      wd_q <= 32'h0000_0000;
      up_q <= 2'h0;
    end else begin
      dn_q <= ph_q && !hreadyout;
      if (ph_q && !hreadyout) begin
        da_q <= pa_q;
        dw_q <= pw_q;
        wd_q <= hwdata;
      end
      if (hsel && htrans[1] && hready) begin
        ph_q <= 1'b1;
        pa_q <= haddr[15:0];
        pw_q <= hwrite;
      end else if (!hreadyout) begin
        ph_q <= 1'b0;
      end
      if (up_q != 2'h3) begin
        up_q <= up_q + 2'h1;
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  property p_okay; hresp == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("hresp not okay");
  property p_wait; hsel && htrans[1] && hready |=> !hreadyout ##1 hreadyout; endproperty
  a_wait: assert property (p_wait) else $error("data phase length wrong");
  property p_sum; rd && da_q == 16'h0528 |->
    ((|hrdata[18:16]) || (|hrdata[1:0])) == $past(pin_event_any); endproperty
  a_sum: assert property (p_sum) else $error("summary differs from status");
  property p_stat; rd && da_q == 16'h0528 |-> hrdata[31:19] == 13'h0 && hrdata[15:2] == 14'h0;
  endproperty
  a_stat: assert property (p_stat) else $error("status spare bits set");
  property p_idx; rd && da_q == 16'h0520 |-> (hrdata & 32'hfffe_fefc) == 32'h0; endproperty
  a_idx: assert property (p_idx) else $error("index spare bits set");
  property p_ctl; rd && da_q == 16'h052c |-> hrdata[31:9] == 23'h0; endproperty
  a_ctl: assert property (p_ctl) else $error("control spare bits set");
  property p_hold; $changed(hrdata) |-> rd; endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_clr; $fell(pin_event_any) |->
    wr && da_q == 16'h0528 && ((|wd_q[18:16]) || (|wd_q[1:0])); endproperty
  a_clr: assert property (p_clr) else $error("status cleared unasked");
  property p_oe; up_q == 2'h3 && $changed(pin_oe) |-> wrc || $past(wrc); endproperty
  a_oe: assert property (p_oe) else $error("pin direction moved unasked");
endmodule

bind ptp_gpio_event_unit_control ptp_event_props ptp_event_props_inst (
  .clk_sys(clk_sys), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pin_in(pin_in),
  .pin_out(pin_out), .pin_oe(pin_oe), .pin_event_any(pin_event_any)
);

/* File: dv/gpio_pin_model.sv */
`timescale 1ns/1ns
// Outside world on the two event pins
module gpio_pin_model (
  input  wire logic [1:0] pin_out,
  input  wire logic [1:0] pin_oe,
  input  wire logic [1:0] ext_lvl,  // Level driven from outside
  output logic      [1:0] pin_in
);
  // Outside drives only an input pin, so no contention ever arises
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule

/* File: dv/test_ptp_gpio_event_unit_control.sv */
`timescale 1ns/1ns
module test_ptp_gpio_event_unit_control;
  logic        clk_sys = 1'b0;
  logic        rst_b   = 1'b0;
  logic        hsel    = 1'b0;
  logic [31:0] haddr   = 32'h0000_0000;
  logic [1:0]  htrans  = 2'h0;
  logic        hwrite  = 1'b0;
  logic [2:0]  hsize   = 3'h2;  // Word transfers only
  logic [31:0] hwdata  = 32'h0000_0000;
  logic [1:0]  ext_lvl = 2'h0;
  logic        hready;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic [1:0]  pin_in;
  logic [1:0]  pin_out;
  logic [1:0]  pin_oe;
  logic        pin_event_any;
  int          num_errors = 0;
  int          comparisons = 0;
  int          u;
  int          n0;
  int          n1;
  logic [31:0] st;

  always #20 clk_sys = ~clk_sys;
  assign hready = hreadyout;  // Single slave

  ptp_gpio_event_unit_control ptp_gpio_event_unit_control_inst (
    .clk_sys(clk_sys), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_event_any(pin_event_any));
  gpio_pin_model gpio_pin_model_inst (
    .pin_out(pin_out), .pin_oe(pin_oe), .ext_lvl(ext_lvl), .pin_in(pin_in));

  task automatic tally_and_finish;
    if (num_errors == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // A bus that never answers counts as a mismatch and ends the run
  task automatic wait_ready;
    int i;
    for (i = 0; i < 50; i++) begin
      @(posedge clk_sys);
      if (hready === 1'b1) break;
    end
    if (i == 50) begin
      num_errors++;
      tally_and_finish();
    end
  endtask

  // One single word transfer; the answer is taken at the closing edge
  task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {16'h0000, a};
    hwrite <= w;
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    q = hrdata;
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rdm(input logic [15:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    check($sformatf("reg_%h", a), q & m, e);
  endtask

  // Enables the selected unit and counts cycles until its pin moves
  task automatic fire(input logic [31:0] ctl, input int p, output int n);
    logic [1:0] was;
    was = pin_out;
    wr(16'h052c, ctl);  // Only single units are enabled, no chains
    rdm(16'h052c, 32'h0000_0018, 32'h0000_0018);
    for (n = 0; n < 200; n++) begin
      @(posedge clk_sys);
      if (pin_out !== was) break;
    end
    // A pin that never moves ends the run as a failure
    if (n == 200) begin
      num_errors++;
      tally_and_finish();
    end
    check("pin_out", 32'(pin_out), 32'(was ^ (2'b01 << p)));
    rdm(16'h052c, 32'h0000_0018, 32'h0000_0000);
  endtask

  // Rising edges on one input pin, each held past the synchroniser
  task automatic pulse(input int c, input int k);
    repeat (k) begin
      ext_lvl[c] <= 1'b1;
      repeat (4) @(posedge clk_sys);
      ext_lvl[c] <= 1'b0;
      repeat (4) @(posedge clk_sys);
    end
  endtask

  initial begin
    repeat (10) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    @(posedge clk_sys);
    check("pin_oe", 32'(pin_oe), 32'h0000_0003);
    rdm(16'h0528, 32'hffff_ffff, 32'h0000_0000);
    rdm(16'h052c, 32'hffff_ffff, 32'h0000_0000);
    rdm(16'h0600, 32'hffff_ffff, 32'h0000_0000);
    wr(16'h0520, 32'hffff_ffff);
    rdm(16'h0520, 32'hffff_ffff, 32'h0001_0103);
    wr(16'h052c, 32'h0000_0008);
    rdm(16'h052c, 32'h0000_0018, 32'h0000_0000);
    rdm(16'h0524, 32'hffff_ffff, 32'h0000_0000);
    st = 32'h0000_0000;
    for (u = 0; u < 3; u++) begin
      wr(16'h0520, 32'(u));
      wr(16'h05c0, 32'h0000_2801);
      fire(32'h0000_0008, (u == 1) ? 1 : 0, n0);
      st = st | (32'h0001_0000 << u);
      rdm(16'h0528, 32'hffff_ffff, st);
      check("pin_event_any", 32'(pin_event_any), 32'h0000_0001);
    end
    wr(16'h0528, 32'h0000_0003);
    rdm(16'h0528, 32'hffff_ffff, 32'h0007_0000);
    wr(16'h0528, 32'h0001_0000);
    rdm(16'h0528, 32'hffff_ffff, 32'h0006_0000);
    wr(16'h0528, 32'h0006_0000);
    check("pin_event_any", 32'(pin_event_any), 32'h0000_0000);
    // Quiet unit 0, then direct against flopped pin drive
    wr(16'h0520, 32'h0000_0000);
    wr(16'h05c0, 32'h0000_2800);
    fire(32'h0000_0008, 0, n0);
    fire(32'h0000_0108, 0, n1);
    check("out_sel_lead", 32'(n0 - n1), 32'h0000_0001);
    rdm(16'h0528, 32'hffff_ffff, 32'h0000_0000);
    // Target already passed: error, no activity
    wr(16'h05c0, 32'h0000_0001);
    wr(16'h052c, 32'h0000_0008);
    rdm(16'h052c, 32'h0000_0018, 32'h0000_0008);
    rdm(16'h0524, 32'h0001_0000, 32'h0001_0000);
    wr(16'h052c, 32'h0000_0000);
    rdm(16'h0524, 32'h0001_0000, 32'h0000_0000);
    wr(16'h0528, 32'h0001_0000);
    // Soft reset in mid count
    wr(16'h05c0, 32'h0000_2801);
    wr(16'h052c, 32'h0000_0008);
    wr(16'h052c, 32'h0000_0004);
    rdm(16'h052c, 32'h0000_001c, 32'h0000_0004);
    rdm(16'h05c0, 32'hffff_ffff, 32'h0000_0000);
    wr(16'h052c, 32'h0000_0000);
    repeat (50) @(posedge clk_sys);
    rdm(16'h0528, 32'hffff_ffff, 32'h0000_0000);
    wr(16'h05c0, 32'h0000_2801);
    fire(32'h0000_0008, 0, n0);
    wr(16'h0528, 32'h0001_0000);
    // Capture units, each on its own pin
    for (u = 0; u < 2; u++) begin
      wr(16'h0520, (u == 1) ? 32'h0001_0100 : 32'h0000_0000);
      wr(16'h052c, 32'h0000_0062);
      @(posedge clk_sys);  // Direction reaches the pin one edge after the write lands
      check("pin_oe", 32'(pin_oe), (u == 1) ? 32'h0000_0000 : 32'h0000_0002);
      pulse(u, 2);
      ext_lvl[u] <= 1'b1;
      repeat (4) @(posedge clk_sys);
      rdm(16'h052c, 32'h0000_0080, 32'h0000_0080);
      ext_lvl[u] <= 1'b0;
      repeat (4) @(posedge clk_sys);
      rdm(16'h05c4, 32'hffff_ffff, 32'h0000_0103);
      rdm(16'h0528, 32'hffff_ffff, 32'h0000_0001 << u);
      wr(16'h052c, 32'h0000_0060);
      rdm(16'h05c4, 32'hffff_ffff, 32'h0000_0003);
      wr(16'h052c, 32'h0000_0062);
      rdm(16'h05c4, 32'hffff_ffff, 32'h0000_0000);
      wr(16'h0528, 32'h0000_0001 << u);
    end
    pulse(1, 16);
    rdm(16'h05c4, 32'hffff_ffff, 32'h0000_030f);
    wr(16'h052c, 32'h0000_0060);
    rdm(16'h05c4, 32'hffff_ffff, 32'h0000_000f);
    wr(16'h0528, 32'h0000_0002);
    wr(16'h052c, 32'h0000_0042);
    pulse(1, 1);
    rdm(16'h0528, 32'hffff_ffff, 32'h0000_0000);
    rdm(16'h05c4, 32'hffff_ffff, 32'h0000_0101);
    tally_and_finish();
  end
endmodule
